// >>> tdd_pkg.sv
// Behaviour
// - Tamper monitoring runs only while the enable control bit is set.
// - Criterion: difference of samples exceeds threshold fraction of their mean.
// - Threshold fraction is 12.5% or 6.25%, picked by threshold_select.
// - Opposite energy signs force tamper at once; larger channel is used.
// - In single wire operation apparent energy replaces active energy.
// - After reset the state machine sits in normal, no tamper.
// - Normal state alternates 32 periods primary, 32 periods secondary.
// - Comparison window opens 4 periods before switch, lasts 8 periods.
// - Sample A is 4 primary periods, sample B the next 4 secondary.
// - Tamper state entered after four consecutive matching results, or at once on opposite signs.
// - Tamper ratio is 60:4 if primary higher, else 4:60.
// - In tamper the gap reuses the last higher-channel value, no averaging.
// - During the gap the other channel is still sampled for comparison.
// - Status bit reads 1 while a tamper state holds, else 0.
// - Bad period, stuck input or no load force normal and disable.
// - Standalone mode drives the tamper bit onto a dedicated pin.
package tdd_pkg;

  // Register byte offsets
  localparam logic [3:0] TDD_ADR_CTRL = 4'h0;
  localparam logic [3:0] TDD_ADR_STATUS = 4'h4;
  localparam logic [3:0] TDD_ADR_IRQ_STAT = 4'h8;
  localparam logic [3:0] TDD_ADR_IRQ_MASK = 4'hc;

  // Control field positions
  localparam int TDD_CTRL_ENABLE = 0;
  localparam int TDD_CTRL_THR_SEL = 1;
  localparam int TDD_CTRL_STANDALONE = 2;

  // Status field position of the tamper bit
  localparam int TDD_STAT_TAMPER = 0;

  // Interrupt event bit positions
  localparam int TDD_IRQ_CHANGE = 0;
  localparam int TDD_IRQ_RESULT = 1;
  localparam int TDD_IRQ_HIT = 2;
  localparam int TDD_IRQ_BITS = 3;

  // Reset values
  localparam logic [2:0] TDD_CTRL_RESET = 3'h0;
  localparam logic [2:0] TDD_MASK_RESET = 3'h0;

  // Multiplex switch points within a 64 period frame
  localparam logic [5:0] TDD_SW_NORMAL = 6'h20;
  localparam logic [5:0] TDD_SW_PRI = 6'h3c;
  localparam logic [5:0] TDD_SW_SEC = 6'h04;
  localparam logic [5:0] TDD_SAMPLE_LEN = 6'h04;
  localparam logic [2:0] TDD_CONS_NEEDED = 3'h4;

  // Shifts giving fraction times mean: 12.5% and 6.25%
  localparam int TDD_SHIFT_HI = 4;
  localparam int TDD_SHIFT_LO = 5;

  typedef enum logic [1:0] {
    ST_NORMAL = 2'b00,
    ST_TAMP_PRI = 2'b01,
    ST_TAMP_SEC = 2'b10
  } tdd_state_t;

endpackage

// >>> tdd_threshold_select.sv
`timescale 1ns/1ns
module tdd_threshold_select import tdd_pkg::*; #(
  parameter int W = 27
) (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic rst,
  // Samples in
  input wire logic in_valid,
  input wire logic signed [W-1:0] samp_a,
  input wire logic signed [W-1:0] samp_b,
  input wire logic thr_sel,
  // Result out
  output logic out_valid,
  output logic hit_o,
  output logic a_gt_o,
  output logic opp_o
);

  logic [W-1:0] mag_a;
  logic [W-1:0] mag_b;
  logic [W-1:0] diff;
  logic [W:0] sum;
  logic [W:0] thr;
  logic opp_c;

  // Magnitudes; the most negative value still fits unsigned
  always_comb begin
    mag_a = samp_a[W-1] ? W'(-samp_a) : W'(samp_a);
    mag_b = samp_b[W-1] ? W'(-samp_b) : W'(samp_b);
    diff = (mag_a > mag_b) ? mag_a - mag_b : mag_b - mag_a;
    sum = {1'b0, mag_a} + {1'b0, mag_b};
    thr = thr_sel ? (sum >> TDD_SHIFT_LO) : (sum >> TDD_SHIFT_HI);
    opp_c = samp_a[W-1] ^ samp_b[W-1];
  end

  // One result per window, registered
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      out_valid <= 1'b0;
      hit_o <= 1'b0;
      a_gt_o <= 1'b0;
      opp_o <= 1'b0;
    end else begin
      out_valid <= in_valid;
      if (in_valid) begin
        hit_o <= opp_c | ({1'b0, diff} > thr);
        a_gt_o <= mag_a > mag_b;
        opp_o <= opp_c;
      end
    end
  end

  // Helper: criterion in multiplied form, independent of the shifts
  logic [W+5:0] lhs_hi;
  logic [W+5:0] lhs_lo;
  logic [W+5:0] sum_x;
  logic exp_hit;
  assign lhs_hi = {2'b00, diff, 4'h0};
  assign lhs_lo = {1'b0, diff, 5'h00};
  assign sum_x = {5'h00, sum};
  assign exp_hit = opp_c || (thr_sel ? lhs_lo > sum_x : lhs_hi > sum_x);

  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (rst);

  threshold_select_formula_a: assert property (in_valid |=> hit_o == $past(exp_hit))
    else $error("criterion result disagrees with threshold formula");

endmodule

// >>> tdd_tamper.sv
`timescale 1ns/1ns
module tdd_tamper import tdd_pkg::*; #(
  parameter int EW = 24
) (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic rst,
  // Wishbone slave
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [3:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  // Energy datapath and detectors
  input wire logic period_tick,
  input wire logic signed [EW-1:0] active_pri,
  input wire logic signed [EW-1:0] active_sec,
  input wire logic signed [EW-1:0] apparent_pri,
  input wire logic signed [EW-1:0] apparent_sec,
  input wire logic single_wire_operation,
  input wire logic line_period_error_flag,
  input wire logic sd_stuck_flag,
  input wire logic no_load_flag,
  // Channel control and status
  output logic chan_sel,
  output logic hold_last,
  output logic tamper_detected,
  output logic standalone_status_out,
  output logic irq
);

  localparam int AW = EW + 3;

  logic ctrl_enable_reg;
  logic thr_sel_reg;
  logic standalone_reg;
  logic [TDD_IRQ_BITS-1:0] irq_stat_reg;
  logic [TDD_IRQ_BITS-1:0] irq_mask_reg;
  tdd_state_t state_reg;
  tdd_state_t state_next;
  tdd_state_t cand_reg;
  tdd_state_t res_class;
  logic [2:0] cons_reg;
  logic [5:0] pcnt_reg;
  logic [5:0] sw_point;
  logic [5:0] win_start;
  logic [5:0] win_end;
  logic signed [AW-1:0] acc_a_reg;
  logic signed [AW-1:0] acc_b_reg;
  logic signed [AW-1:0] e_pri;
  logic signed [AW-1:0] e_sec;
  logic signed [AW-1:0] samp_b;
  logic in_win_a;
  logic in_win_b;
  logic inhibit;
  logic cmp_go;
  logic res_valid;
  logic res_hit;
  logic res_a_gt;
  logic res_opp;
  logic last_hit_reg;
  logic wb_req;
  logic wb_wr;
  logic [TDD_IRQ_BITS-1:0] events;

  // Bad inputs or disabled: the whole block rests in normal
  assign inhibit = !ctrl_enable_reg | line_period_error_flag
                 | sd_stuck_flag | no_load_flag;

  // Apparent energy stands in when no voltage phase exists
  assign e_pri = single_wire_operation ? AW'(apparent_pri) : AW'(active_pri);
  assign e_sec = single_wire_operation ? AW'(apparent_sec) : AW'(active_sec);

  // Switch point of the current multiplex ratio
  always_comb begin
    unique case (state_reg)
      ST_NORMAL: sw_point = TDD_SW_NORMAL;
      ST_TAMP_PRI: sw_point = TDD_SW_PRI;
      ST_TAMP_SEC: sw_point = TDD_SW_SEC;
      default: sw_point = TDD_SW_NORMAL;
    endcase
  end

  // Window spans four periods either side of the switch point
  assign win_start = sw_point - TDD_SAMPLE_LEN;
  assign win_end = sw_point + TDD_SAMPLE_LEN - 6'h01;
  assign in_win_a = (pcnt_reg >= win_start) && (pcnt_reg < sw_point);
  assign in_win_b = (pcnt_reg >= sw_point) && (pcnt_reg <= win_end);
  assign cmp_go = period_tick && !inhibit && (pcnt_reg == win_end);
  assign samp_b = acc_b_reg + e_sec;

  // Line period counter; a 64 period frame wraps naturally
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      pcnt_reg <= 6'h00;
    end else if (inhibit) begin
      pcnt_reg <= 6'h00;
    end else if (period_tick) begin
      pcnt_reg <= pcnt_reg + 6'h01;
    end
  end

  // Sample A accumulates primary energy before the switch
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      acc_a_reg <= '0;
    end else if (inhibit) begin
      acc_a_reg <= '0;
    end else if (period_tick && in_win_a) begin
      if (pcnt_reg == win_start) begin
        acc_a_reg <= e_pri;
      end else begin
        acc_a_reg <= acc_a_reg + e_pri;
      end
    end
  end

  // Sample B accumulates secondary energy after it, in the gap when primary tamper holds
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      acc_b_reg <= '0;
    end else if (inhibit) begin
      acc_b_reg <= '0;
    end else if (period_tick && in_win_b) begin
      if (pcnt_reg == sw_point) begin
        acc_b_reg <= e_sec;
      end else begin
        acc_b_reg <= samp_b;
      end
    end
  end

  // Criterion evaluation, one cycle of latency
  tdd_threshold_select #(
    .W(AW)
  ) u_threshold_select (
    .sys_clk(sys_clk),
    .rst(rst),
    .in_valid(cmp_go),
    .samp_a(acc_a_reg),
    .samp_b(samp_b),
    .thr_sel(thr_sel_reg),
    .out_valid(res_valid),
    .hit_o(res_hit),
    .a_gt_o(res_a_gt),
    .opp_o(res_opp)
  );

  // Which state a single result points at
  always_comb begin
    if (res_hit) begin
      res_class = res_a_gt ? ST_TAMP_PRI : ST_TAMP_SEC;
    end else begin
      res_class = ST_NORMAL;
    end
  end

  // Run of consecutive results pointing at the same state
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      cand_reg <= ST_NORMAL;
      cons_reg <= 3'h0;
      last_hit_reg <= 1'b0;
    end else if (inhibit) begin
      cand_reg <= ST_NORMAL;
      cons_reg <= 3'h0;
    end else if (res_valid) begin
      last_hit_reg <= res_hit;
      if (res_class == cand_reg) begin
        if (cons_reg != TDD_CONS_NEEDED) begin
          cons_reg <= cons_reg + 3'h1;
        end
      end else begin
        cand_reg <= res_class;
        cons_reg <= 3'h1;
      end
    end
  end

  // Next state: sign conflict acts at once, others need a full run
  always_comb begin
    state_next = state_reg;
    if (inhibit) begin
      state_next = ST_NORMAL;
    end else if (res_valid && res_opp) begin
      state_next = res_class;
    end else if (res_valid && res_class == cand_reg
                 && cons_reg == TDD_CONS_NEEDED - 3'h1) begin
      state_next = res_class;
    end
  end

  // State register starts in normal
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      state_reg <= ST_NORMAL;
    end else begin
      state_reg <= state_next;
    end
  end

  // Channel steering; the gap reuses the held higher channel value
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      chan_sel <= 1'b0;
      hold_last <= 1'b0;
    end else begin
      unique case (state_reg)
        ST_NORMAL: begin
          chan_sel <= pcnt_reg >= TDD_SW_NORMAL;
          hold_last <= 1'b0;
        end
        ST_TAMP_PRI: begin
          chan_sel <= 1'b0;
          hold_last <= pcnt_reg >= TDD_SW_PRI;
        end
        ST_TAMP_SEC: begin
          chan_sel <= 1'b1;
          hold_last <= pcnt_reg < TDD_SW_SEC;
        end
        default: begin
          chan_sel <= 1'b0;
          hold_last <= 1'b0;
        end
      endcase
    end
  end

  // Status outputs; pin only driven in standalone mode
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      tamper_detected <= 1'b0;
      standalone_status_out <= 1'b0;
    end else begin
      tamper_detected <= state_reg != ST_NORMAL;
      standalone_status_out <= standalone_reg && state_reg != ST_NORMAL;
    end
  end

  // Wishbone: every access answers one cycle later, unmapped reads zero
  assign wb_req = wb_cyc_i && wb_stb_i && !wb_ack_o;
  assign wb_wr = wb_req && wb_we_i && wb_sel_i[0];

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      wb_ack_o <= 1'b0;
    end else begin
      wb_ack_o <= wb_req;
    end
  end

  // Read data captured with the request
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      wb_dat_o <= 32'h0000_0000;
    end else if (wb_req && !wb_we_i) begin
      unique case (wb_adr_i)
        TDD_ADR_CTRL: wb_dat_o <= {29'h0, standalone_reg, thr_sel_reg, ctrl_enable_reg};
        TDD_ADR_STATUS: wb_dat_o <= {25'h0, cons_reg, last_hit_reg, state_reg,
                                     state_reg != ST_NORMAL};
        TDD_ADR_IRQ_STAT: wb_dat_o <= {29'h0, irq_stat_reg};
        TDD_ADR_IRQ_MASK: wb_dat_o <= {29'h0, irq_mask_reg};
        default: wb_dat_o <= 32'h0000_0000;
      endcase
    end else begin
      wb_dat_o <= 32'h0000_0000;
    end
  end

  // Control register
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      {standalone_reg, thr_sel_reg, ctrl_enable_reg} <= TDD_CTRL_RESET;
    end else if (wb_wr && wb_adr_i == TDD_ADR_CTRL) begin
      ctrl_enable_reg <= wb_dat_i[TDD_CTRL_ENABLE];
      thr_sel_reg <= wb_dat_i[TDD_CTRL_THR_SEL];
      standalone_reg <= wb_dat_i[TDD_CTRL_STANDALONE];
    end
  end

  // Sticky events; a new event beats a same-cycle clear
  always_comb begin
    events = '0;
    events[TDD_IRQ_CHANGE] = state_next != state_reg;
    events[TDD_IRQ_RESULT] = res_valid;
    events[TDD_IRQ_HIT] = res_valid && res_hit;
  end

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      irq_stat_reg <= '0;
    end else if (wb_wr && wb_adr_i == TDD_ADR_IRQ_STAT) begin
      irq_stat_reg <= (irq_stat_reg & ~wb_dat_i[TDD_IRQ_BITS-1:0]) | events;
    end else begin
      irq_stat_reg <= irq_stat_reg | events;
    end
  end

  // Mask register and level interrupt
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      irq_mask_reg <= TDD_MASK_RESET;
    end else if (wb_wr && wb_adr_i == TDD_ADR_IRQ_MASK) begin
      irq_mask_reg <= wb_dat_i[TDD_IRQ_BITS-1:0];
    end
  end

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      irq <= 1'b0;
    end else begin
      irq <= |(irq_stat_reg & irq_mask_reg);
    end
  end

  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (rst);

  reset_normal_a: assert property ($past(rst) |-> state_reg == ST_NORMAL)
    else $error("state not normal after reset");

  disable_gate_a: assert property (!ctrl_enable_reg |-> !cmp_go ##1 !res_valid)
    else $error("comparison ran while disabled");

  force_normal_a: assert property (inhibit |=> state_reg == ST_NORMAL && cons_reg == 3'h0)
    else $error("inhibit did not force normal");

  normal_ratio_a: assert property ($past(state_reg) == ST_NORMAL |->
    chan_sel == ($past(pcnt_reg) >= 6'd32) && !hold_last)
    else $error("normal multiplex not 32:32");

  tamper_ratio_a: assert property ($past(state_reg) == ST_TAMP_PRI |->
    !chan_sel && hold_last == ($past(pcnt_reg) >= 6'd60))
    else $error("primary tamper ratio not 60:4");

  tamper_gap_a: assert property ($past(state_reg) == ST_TAMP_SEC |->
    chan_sel && hold_last == ($past(pcnt_reg) < 6'd4))
    else $error("secondary tamper gap wrong");

  window_edge_a: assert property (cmp_go |-> period_tick && pcnt_reg ==
    (state_reg == ST_NORMAL ? 6'd35 : state_reg == ST_TAMP_PRI ? 6'd63 : 6'd7))
    else $error("comparison outside window end");

  four_in_row_a: assert property (state_reg == ST_NORMAL ##1 state_reg != ST_NORMAL
    |-> $past(res_valid) && ($past(cons_reg) == 3'd3 || $past(res_opp)))
    else $error("tamper entered without four results");

  sign_conflict_a: assert property (res_valid && res_opp && !inhibit |=>
    state_reg != ST_NORMAL)
    else $error("opposite signs did not force tamper");

  status_bit_a: assert property (##1 tamper_detected == ($past(state_reg) != ST_NORMAL))
    else $error("tamper status bit wrong");

  pin_mirror_a: assert property (standalone_status_out ==
    ($past(standalone_reg) && tamper_detected))
    else $error("standalone pin does not follow tamper bit");

  enter_pri_c: cover property (state_reg == ST_NORMAL ##1 state_reg == ST_TAMP_PRI);
  enter_sec_c: cover property (state_reg == ST_NORMAL ##1 state_reg == ST_TAMP_SEC);
  back_normal_c: cover property (state_reg != ST_NORMAL ##1 state_reg == ST_NORMAL);
  swap_tamper_c: cover property (state_reg == ST_TAMP_PRI ##1 state_reg == ST_TAMP_SEC);

endmodule

// >>> tdd_energy_src.sv
`timescale 1ns/1ns
module tdd_energy_src #(
  parameter int EW = 24,
  parameter int TICK_GAP = 4
) (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic rst,
  // Energy levels chosen by the bench
  input wire logic signed [EW-1:0] set_pri,
  input wire logic signed [EW-1:0] set_sec,
  input wire logic signed [EW-1:0] set_app_pri,
  input wire logic signed [EW-1:0] set_app_sec,
  // Towards the tamper block
  output logic period_tick,
  output logic signed [EW-1:0] active_pri,
  output logic signed [EW-1:0] active_sec,
  output logic signed [EW-1:0] apparent_pri,
  output logic signed [EW-1:0] apparent_sec
);
  logic [7:0] gap_reg;

  // Line period divider, ticks stay evenly spaced so run lengths count exactly
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      gap_reg <= 8'h00;
      period_tick <= 1'b0;
    end else if (gap_reg == 8'(TICK_GAP - 1)) begin
      gap_reg <= 8'h00;
      period_tick <= 1'b1;
    end else begin
      gap_reg <= gap_reg + 8'h01;
      period_tick <= 1'b0;
    end
  end

  // Words only hold outside the tick cycle as their inverse, so late sampling shows
  assign active_pri = period_tick ? set_pri : ~set_pri;
  assign active_sec = period_tick ? set_sec : ~set_sec;
  assign apparent_pri = period_tick ? set_app_pri : ~set_app_pri;
  assign apparent_sec = period_tick ? set_app_sec : ~set_app_sec;
endmodule

// >>> tdd_tamper_tb.sv
`timescale 1ns/1ns
module tdd_tamper_tb import tdd_pkg::*;;
  logic sys_clk, rst, cyc, stb, we, sw_op, tick, ack;
  logic chan_sel, hold_last, tamper, sa_out, irq;
  logic [3:0] adr, sel;
  logic [2:0] flags;
  logic [31:0] wdat, rdat, rd, st, ev;
  logic signed [23:0] e_pri, e_sec, a_pri, a_sec, act_p, act_s, app_p, app_s;
  int error_cnt, n_compared, n;

  // Free running system clock
  initial begin
    sys_clk = 1'b0;
    forever #25 sys_clk = ~sys_clk;
  end

  tdd_energy_src #(.EW(24), .TICK_GAP(4)) src_u (.sys_clk(sys_clk), .rst(rst),
    .set_pri(e_pri), .set_sec(e_sec), .set_app_pri(a_pri), .set_app_sec(a_sec),
    .period_tick(tick), .active_pri(act_p), .active_sec(act_s),
    .apparent_pri(app_p), .apparent_sec(app_s));

  tdd_tamper #(.EW(24)) dut_u (.sys_clk(sys_clk), .rst(rst), .wb_cyc_i(cyc),
    .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat),
    .wb_dat_o(rdat), .wb_ack_o(ack), .period_tick(tick), .active_pri(act_p),
    .active_sec(act_s), .apparent_pri(app_p), .apparent_sec(app_s),
    .single_wire_operation(sw_op), .line_period_error_flag(flags[0]),
    .sd_stuck_flag(flags[1]), .no_load_flag(flags[2]), .chan_sel(chan_sel),
    .hold_last(hold_last), .tamper_detected(tamper),
    .standalone_status_out(sa_out), .irq(irq));

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp) begin
      error_cnt++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // One classic cycle; request held until ack is sampled high
  task automatic xfer(input logic w, input logic [3:0] a, input logic [31:0] d);
    int k;
    @(posedge sys_clk);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    wdat <= d;
    sel <= 4'hf;
    k = 0;
    do begin
      @(posedge sys_clk);
      k++;
    end while (ack !== 1'b1 && k < 20);
    chk(32'(k < 20), 32'h1);
    rd = rdat;
    cyc <= 1'b0;
    stb <= 1'b0;
    we <= 1'b0;
  endtask

  task automatic rd_chk(input logic [3:0] a, input logic [31:0] exp);
    xfer(1'b0, a, 32'h0);
    chk(rd, exp);
  endtask

  // Disable clears the frame count, then enable with result interrupt unmasked
  task automatic restart(input logic [31:0] c);
    xfer(1'b1, TDD_ADR_CTRL, 32'h0);
    xfer(1'b1, TDD_ADR_CTRL, c);
    xfer(1'b1, TDD_ADR_IRQ_STAT, 32'h7);
    xfer(1'b1, TDD_ADR_IRQ_MASK, 32'h2);
  endtask

  // Waits for the next comparison result, keeps status and event words, clears events
  task automatic wait_result;
    int k;
    k = 0;
    while (irq !== 1'b1 && k < 600) begin
      @(posedge sys_clk);
      k++;
    end
    chk(32'(k < 600), 32'h1);
    xfer(1'b0, TDD_ADR_STATUS, 32'h0);
    st = rd;
    xfer(1'b0, TDD_ADR_IRQ_STAT, 32'h0);
    ev = rd;
    xfer(1'b1, TDD_ADR_IRQ_STAT, 32'h7);
    @(posedge sys_clk);
    chk(32'(irq), 32'h0);
  endtask

  // Counts ticks over one whole run of chan_sel or hold_last at level lvl
  task automatic run_len(input logic hold, input logic lvl, output int cnt);
    int k;
    k = 0;
    cnt = 0;
    while ((hold ? hold_last : chan_sel) === lvl && k < 4000) begin
      @(posedge sys_clk);
      k++;
    end
    while ((hold ? hold_last : chan_sel) !== lvl && k < 4000) begin
      @(posedge sys_clk);
      k++;
    end
    while ((hold ? hold_last : chan_sel) === lvl && k < 4000) begin
      @(posedge sys_clk);
      k++;
      if (tick === 1'b1) cnt++;
    end
  endtask

  task automatic summarize;
    $display("compared %0d, errors %0d", n_compared, error_cnt);
    if (error_cnt == 0 && n_compared > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask

  // Watchdog sized well above the expected run of about 6000 cycles
  initial begin
    repeat (30000) @(posedge sys_clk);
    chk(32'h0, 32'h1);
    summarize;
  end

  initial begin
    {rst, cyc, stb, we, sw_op} = 5'h10;
    {adr, sel, flags, wdat} = '0;
    {e_pri, e_sec, a_pri, a_sec} = '0;
    error_cnt = 0;
    n_compared = 0;
    repeat (4) @(posedge sys_clk);
    rst <= 1'b0;
    // Reset values, unmapped and read-only places
    for (int i = 0; i < 5; i++) rd_chk((i == 4) ? 4'h2 : 4'(i * 4), 32'h0);
    chk(32'({tamper, chan_sel, hold_last, sa_out, irq}), 32'h0);
    xfer(1'b1, 4'h2, 32'hff);
    rd_chk(4'h2, 32'h0);
    xfer(1'b1, TDD_ADR_STATUS, 32'hff);
    rd_chk(TDD_ADR_STATUS, 32'h0);
    xfer(1'b1, TDD_ADR_IRQ_MASK, 32'hff);
    rd_chk(TDD_ADR_IRQ_MASK, 32'h7);
    // Disabled block ignores even opposite signs
    e_pri <= 24'h0003e8;
    e_sec <= 24'hfffe0c;
    n = 0;
    repeat (600) begin
      @(posedge sys_clk);
      if (chan_sel !== 1'b0 || tamper !== 1'b0) n++;
    end
    chk(32'(n), 32'h0);
    rd_chk(TDD_ADR_IRQ_STAT, 32'h0);
    // Normal multiplex, equal weight
    e_sec <= 24'h0003e8;
    restart(32'h1);
    run_len(1'b0, 1'b1, n);
    chk(32'(n), 32'h20);
    run_len(1'b0, 1'b0, n);
    chk(32'(n), 32'h20);
    chk(32'(hold_last), 32'h0);
    // Masked event stays silent until unmasked
    xfer(1'b1, TDD_ADR_IRQ_MASK, 32'h0);
    repeat (300) @(posedge sys_clk);
    chk(32'(irq), 32'h0);
    rd_chk(TDD_ADR_IRQ_STAT, 32'h2);
    xfer(1'b1, TDD_ADR_IRQ_MASK, 32'h2);
    @(posedge sys_clk);
    chk(32'(irq), 32'h1);
    // Threshold select and single wire source, 1000 against 900 per period
    for (int i = 0; i < 4; i++) begin
      sw_op <= (i >= 2);
      e_sec <= (i == 2) ? 24'h0003e8 : 24'h000384;
      a_pri <= 24'h0003e8;
      a_sec <= (i == 2) ? 24'h000384 : 24'h0003e8;
      restart((i == 0) ? 32'h1 : 32'h3);
      wait_result;
      chk(32'(st[3]), 32'((i == 1) || (i == 2)));
    end
    sw_op <= 1'b0;
    // Four hits in a row before primary tamper
    e_sec <= 24'h000320;
    restart(32'h1);
    for (int i = 1; i <= 4; i++) begin
      wait_result;
      chk(ev, (i < 4) ? 32'h6 : 32'h7);
      if (i < 4) chk(32'(st[6:0]), 32'({3'(i), 4'h8}));
      else chk(32'(st[3:0]), 32'hb);
    end
    @(posedge sys_clk);
    chk(32'({tamper, chan_sel, sa_out}), 32'h4);
    xfer(1'b1, TDD_ADR_CTRL, 32'h5);
    @(posedge sys_clk);
    @(posedge sys_clk);
    chk(32'(sa_out), 32'h1);
    run_len(1'b1, 1'b0, n);
    chk(32'(n), 32'h3c);
    run_len(1'b1, 1'b1, n);
    chk(32'(n), 32'h04);
    // Gap samples still compared: four equal results lead back to normal
    e_sec <= 24'h0003e8;
    xfer(1'b1, TDD_ADR_IRQ_STAT, 32'h7); // Results of the run counts would look new
    @(posedge sys_clk);
    for (int i = 1; i <= 4; i++) begin
      wait_result;
      chk(32'(st[0]), 32'(i < 4));
      chk(ev, (i < 4) ? 32'h2 : 32'h3);
    end
    // Opposite signs enter at once, each inhibit flag forces normal
    e_sec <= 24'hfffe0c;
    for (int i = 0; i < 3; i++) begin
      restart(32'h1);
      wait_result;
      chk(32'(st[2:0]), 32'h3);
      chk(ev, 32'h7);
      flags <= 3'(1 << i);
      repeat (4) @(posedge sys_clk);
      chk(32'({tamper, chan_sel, hold_last}), 32'h0);
      rd_chk(TDD_ADR_STATUS, 32'h8);
      flags <= 3'h0;
    end
    // Secondary larger in magnitude: 4:60 toward the secondary channel
    e_pri <= 24'h0000c8;
    e_sec <= 24'hfffc18;
    restart(32'h1);
    wait_result;
    chk(32'(st[2:0]), 32'h5);
    @(posedge sys_clk);
    chk(32'({tamper, chan_sel}), 32'h3);
    run_len(1'b1, 1'b0, n);
    chk(32'(n), 32'h3c);
    run_len(1'b1, 1'b1, n);
    chk(32'(n), 32'h04);
    summarize;
  end
endmodule
